// >>> rtl/ddr2_burst_if.sv
// Purpose: memory side of an x8 ddr2 burst access and data strobe interface
// Assumes: link clock and controller strobe sampled by mclk, apb register access
// Notes: storage is a small flip-flop array indexed by bank and low column bits
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module ddr2_burst_if #(
   parameter int COL_W = 4
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ck,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic bank_select_bit0,
   input wire logic bank_select_bit1,
   input wire logic [13:0] addr,
   input wire logic [7:0] dq_in,
   output logic [7:0] dq_out,
   output logic dq_oe,
   input wire logic dqs_in,
   output logic dqs_out,
   output logic dqs_oe,
   output logic dqs_n_out,
   output logic dqs_n_oe,
   input wire logic write_byte_mask,
   output logic read_only_strobe_out,
   output logic read_only_strobe_oe,
   output logic read_only_strobe_n_out,
   output logic read_only_strobe_n_oe,
   input wire logic termination_enable,
   output logic termination_on
);
   localparam int IDX_W = COL_W + 2;
   localparam int DEPTH = 1 << IDX_W;

   logic [31:0] pin_raw;
   logic [31:0] pin_s;
   logic ck_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, dqs_s, mask_s, term_s;
   logic [1:0] ba_s;
   logic [13:0] addr_s;
   logic [7:0] dq_s;

   // every pin input crosses two flip-flops before use
   assign pin_raw = {ck, cs_n, ras_n, cas_n, we_n, bank_select_bit1, bank_select_bit0, addr, dq_in, dqs_in,
                     write_byte_mask, termination_enable};
   pin_sync #(.W(32)) u_sync (
      .mclk(mclk),
      .nrst(nrst),
      .d(pin_raw),
      .q(pin_s)
   );
   assign {ck_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s, dq_s, dqs_s, mask_s, term_s} = pin_s;

   // ---------------- register file ----------------
   logic [ddr2_burst_pkg::CFG_W-1:0] cfg_q, cfg_d;
   logic [31:0] prdata_d;
   logic pslverr_d;
   logic [31:0] stat_word;
   logic [13:0] last_row_q, last_row_d;
   logic [3:0] open_q, open_d;
   logic auto_q, auto_d;
   ddr2_burst_pkg::burst_state_t state_q, state_d;
   logic bl8, interleave, rstrobe_en, single_ended, term_cfg;

   assign bl8 = cfg_q[ddr2_burst_pkg::CFG_BL8_BIT];
   assign interleave = cfg_q[ddr2_burst_pkg::CFG_INTERLEAVE_BIT];
   assign rstrobe_en = cfg_q[ddr2_burst_pkg::CFG_RSTROBE_BIT];
   assign single_ended = cfg_q[ddr2_burst_pkg::CFG_SINGLE_BIT];
   assign term_cfg = cfg_q[ddr2_burst_pkg::CFG_TERM_BIT];

   always_comb begin
      stat_word = 32'h0;
      stat_word[3:0] = open_q;
      stat_word[ddr2_burst_pkg::STAT_BUSY_BIT] = (state_q != ddr2_burst_pkg::ST_IDLE);
      stat_word[ddr2_burst_pkg::STAT_AUTO_BIT] = auto_q;
   end

   // read data latched in setup phase, answer in the access phase
   assign pready = psel & penable;
   always_comb begin
      cfg_d = cfg_q;
      prdata_d = prdata;
      pslverr_d = pslverr;
      if (psel && !penable) begin
         pslverr_d = 1'b0;
         case (paddr)
            ddr2_burst_pkg::OFF_CFG: prdata_d = {27'h0, cfg_q};
            ddr2_burst_pkg::OFF_STAT: prdata_d = stat_word;
            ddr2_burst_pkg::OFF_ROW: prdata_d = {18'h0, last_row_q};
            default: begin
               prdata_d = 32'h0;
               pslverr_d = 1'b1;
            end
         endcase
      end
      // write takes effect at the edge that completes the access
      if (psel && penable && pwrite && paddr == ddr2_burst_pkg::OFF_CFG) begin
         cfg_d = pwdata[ddr2_burst_pkg::CFG_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cfg_q <= ddr2_burst_pkg::CFG_RESET;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         prdata <= prdata_d;
         pslverr <= pslverr_d;
      end
   end

   // ---------------- link side ----------------
   logic ck_prev_q, dqs_prev_q;
   logic ck_rise, ck_edge, dqs_edge;
   logic [2:0] cmd;
   logic cmd_take;
   logic [3:0] beat_q, beat_d;
   logic [3:0] bl_beats;
   logic [1:0] bank_q, bank_d;
   logic [COL_W-1:0] col_q, col_d;
   logic [COL_W-1:0] beat_col;
   logic [7:0] dq_out_d;
   logic dq_oe_d, dqs_out_d;
   logic mem_we;
   logic burst_end;
   logic [7:0] mem_q [DEPTH];
   logic [IDX_W-1:0] beat_idx;

   assign ck_rise = ck_s & ~ck_prev_q;
   assign ck_edge = ck_s ^ ck_prev_q;
   assign dqs_edge = dqs_s ^ dqs_prev_q;
   assign cmd = {ras_n_s, cas_n_s, we_n_s};
   assign cmd_take = ck_rise & ~cs_n_s;
   assign bl_beats = bl8 ? ddr2_burst_pkg::BL_LONG : ddr2_burst_pkg::BL_SHORT;
   assign beat_idx = {bank_q, beat_col};

   burst_col_gen #(.COL_W(COL_W)) u_col (
      .start_col(col_q),
      .beat(beat_q[2:0]),
      .long_burst(bl8),
      .interleave(interleave),
      .col(beat_col)
   );

   // burst sequencer, bank tracking and strobe generation
   always_comb begin
      state_d = state_q;
      beat_d = beat_q;
      bank_d = bank_q;
      col_d = col_q;
      auto_d = auto_q;
      open_d = open_q;
      last_row_d = last_row_q;
      dq_out_d = dq_out;
      dq_oe_d = dq_oe;
      dqs_out_d = dqs_out;
      mem_we = 1'b0;
      burst_end = 1'b0;
      case (state_q)
         ddr2_burst_pkg::ST_IDLE: begin
            if (cmd_take) begin
               case (cmd)
                  ddr2_burst_pkg::CMD_ACT: begin
                     open_d[ba_s] = 1'b1;
                     last_row_d = addr_s;
                  end
                  ddr2_burst_pkg::CMD_RD, ddr2_burst_pkg::CMD_WR: begin
                     // access to a closed bank is dropped, controller must activate first
                     if (open_q[ba_s]) begin
                        state_d = (cmd == ddr2_burst_pkg::CMD_RD) ? ddr2_burst_pkg::ST_READ
                                                                  : ddr2_burst_pkg::ST_WRITE;
                        bank_d = ba_s;
                        col_d = addr_s[COL_W-1:0];
                        auto_d = addr_s[ddr2_burst_pkg::AUTO_CLOSE_BIT];
                        beat_d = 4'h0;
                     end
                  end
                  ddr2_burst_pkg::CMD_PRE: begin
                     if (addr_s[ddr2_burst_pkg::AUTO_CLOSE_BIT]) begin
                        open_d = 4'h0;
                     end else begin
                        open_d[ba_s] = 1'b0;
                     end
                  end
                  default: ;
               endcase
            end
         end
         ddr2_burst_pkg::ST_READ: begin
            // one beat per link clock edge, strobe toggles with the data
            if (ck_edge) begin
               if (beat_q == bl_beats) begin
                  dq_oe_d = 1'b0;
                  burst_end = 1'b1;
               end else begin
                  dq_out_d = mem_q[beat_idx];
                  dq_oe_d = 1'b1;
                  dqs_out_d = ~beat_q[0];
                  beat_d = beat_q + 4'h1;
               end
            end
         end
         ddr2_burst_pkg::ST_WRITE: begin
            // data and mask captured on both strobe edges
            if (dqs_edge) begin
               mem_we = ~(mask_s & ~rstrobe_en);
               beat_d = beat_q + 4'h1;
               if (beat_q == bl_beats - 4'h1) begin
                  burst_end = 1'b1;
               end
            end
         end
         default: state_d = ddr2_burst_pkg::ST_IDLE;
      endcase
      if (burst_end) begin
         state_d = ddr2_burst_pkg::ST_IDLE;
         dqs_out_d = 1'b0;
         if (auto_q) begin
            open_d[bank_q] = 1'b0;
         end
         auto_d = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_q <= ddr2_burst_pkg::ST_IDLE;
         beat_q <= 4'h0;
         bank_q <= 2'h0;
         col_q <= '0;
         auto_q <= 1'b0;
         open_q <= 4'h0;
         last_row_q <= 14'h0;
         dq_out <= 8'h00;
         dq_oe <= 1'b0;
         dqs_out <= 1'b0;
         ck_prev_q <= 1'b0;
         dqs_prev_q <= 1'b0;
      end else begin
         state_q <= state_d;
         beat_q <= beat_d;
         bank_q <= bank_d;
         col_q <= col_d;
         auto_q <= auto_d;
         open_q <= open_d;
         last_row_q <= last_row_d;
         dq_out <= dq_out_d;
         dq_oe <= dq_oe_d;
         dqs_out <= dqs_out_d;
         ck_prev_q <= ck_s;
         dqs_prev_q <= dqs_s;
      end
   end

   // storage; reset omitted on purpose, content is undefined after power-up
   always_ff @(posedge mclk) begin
      if (mem_we) begin
         mem_q[beat_idx] <= dq_s;
      end
   end

   // strobe pins follow the data enable, read strobe pins only when rstrobe_en is set, complements only when differential
   assign dqs_oe = dq_oe;
   assign dqs_n_out = ~dqs_out;
   assign dqs_n_oe = dq_oe & ~single_ended;
   assign read_only_strobe_out = dqs_out;
   assign read_only_strobe_oe = dq_oe & rstrobe_en;
   assign read_only_strobe_n_out = ~dqs_out;
   assign read_only_strobe_n_oe = dq_oe & rstrobe_en & ~single_ended;
   assign termination_on = term_cfg & term_s;

   // ---------------- checks ----------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   a_dq_drive_read: assert property (dq_oe |-> state_q == ddr2_burst_pkg::ST_READ || $past(burst_end))
      else $error("data bus driven outside a read");
   a_strobe_with_data: assert property ($rose(dq_oe) |-> dqs_oe && dqs_out)
      else $error("first read beat without rising strobe");
   a_rstrobe_mode: assert property (read_only_strobe_oe |-> rstrobe_en && dqs_oe)
      else $error("read strobe driven while mask mode selected");
   a_single_ended: assert property (single_ended |-> !dqs_n_oe && !read_only_strobe_n_oe)
      else $error("complementary strobe driven while disabled");
   a_mask_blocks: assert property (state_q == ddr2_burst_pkg::ST_WRITE && dqs_edge && mask_s && !rstrobe_en
                                   |-> !mem_we)
      else $error("masked beat written");
   a_term_gate: assert property (!term_cfg |-> !termination_on)
      else $error("termination applied while disabled");
   a_burst_length: assert property (state_q == ddr2_burst_pkg::ST_READ && ck_edge && beat_q == bl_beats
                                    |=> state_q == ddr2_burst_pkg::ST_IDLE && !dq_oe)
      else $error("read burst length wrong");
   a_active_opens: assert property (state_q == ddr2_burst_pkg::ST_IDLE && cmd_take && cmd == ddr2_burst_pkg::CMD_ACT
                                    |=> open_q[$past(ba_s)] && last_row_q == $past(addr_s))
      else $error("active did not open the bank");
   a_auto_close: assert property (burst_end && auto_q |=> !open_q[$past(bank_q)])
      else $error("bank left open after auto close burst");
   a_cs_ignore: assert property (ck_rise && cs_n_s && state_q == ddr2_burst_pkg::ST_IDLE
                                 |=> state_q == ddr2_burst_pkg::ST_IDLE && open_q == $past(open_q))
      else $error("command taken while deselected");

   c_read_burst: cover property (state_q == ddr2_burst_pkg::ST_READ && burst_end);
   c_write_burst: cover property (state_q == ddr2_burst_pkg::ST_WRITE && burst_end);
   c_masked_beat: cover property (state_q == ddr2_burst_pkg::ST_WRITE && dqs_edge && mask_s && !rstrobe_en);
   c_long_burst: cover property (burst_end && bl8);
endmodule

// >>> pkg/ddr2_burst_pkg.sv
// Purpose: shared constants for the ddr2 burst and strobe interface block
// Assumes: apb register byte offsets, 25 MHz core clock
// Notes: every offset and single-bit field position and the configuration reset value live here
package ddr2_burst_pkg;
   // apb register byte offsets
   localparam logic [7:0] OFF_CFG = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_ROW = 8'h08;

   // configuration register field positions
   localparam int CFG_BL8_BIT = 0;
   localparam int CFG_INTERLEAVE_BIT = 1;
   localparam int CFG_RSTROBE_BIT = 2;
   localparam int CFG_SINGLE_BIT = 3;
   localparam int CFG_TERM_BIT = 4;
   localparam int CFG_W = 5;
   localparam logic [4:0] CFG_RESET = 5'h00;

   // status register field positions
   localparam int STAT_BUSY_BIT = 4;
   localparam int STAT_AUTO_BIT = 5;

   // burst lengths in beats
   localparam logic [3:0] BL_SHORT = 4'h4;
   localparam logic [3:0] BL_LONG = 4'h8;

   // commands as {row strobe, column strobe, write enable}, all active low
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_RD = 3'h5;
   localparam logic [2:0] CMD_WR = 3'h4;
   localparam logic [2:0] CMD_PRE = 3'h2;

   // address bit that requests automatic bank closing
   localparam int AUTO_CLOSE_BIT = 10;

   // synchroniser depth for every pin input
   localparam int SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_READ,
      ST_WRITE
   } burst_state_t;
endpackage

// >>> rtl/pin_sync.sv
// Purpose: two flip-flop synchroniser for a bundle of pin inputs
// Assumes: each bit is an independent level from outside the clock domain
// Notes: first stage feeds the second stage only
`timescale 1ns/1ns
module pin_sync #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] q_d;

   // next values: shift one stage per edge
   always_comb begin
      meta_d = d;
      q_d = meta_q;
   end

   // plain shift, metastability settles in the first stage
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= meta_d;
         q <= q_d;
      end
   end
endmodule

// >>> rtl/burst_col_gen.sv
// Purpose: column of a given beat inside a burst
// Assumes: burst of four or eight beats, sequential or interleaved order
// Notes: column bits above the burst block never change
`timescale 1ns/1ns
module burst_col_gen #(
   parameter int COL_W = 4
) (
   input wire logic [COL_W-1:0] start_col,
   input wire logic [2:0] beat,
   input wire logic long_burst,
   input wire logic interleave,
   output logic [COL_W-1:0] col
);
   logic [2:0] low_seq;
   logic [2:0] low_int;
   logic [2:0] wrap_mask;
   logic [2:0] low;

   // wrap inside the aligned block of four or eight
   always_comb begin
      wrap_mask = long_burst ? 3'h7 : 3'h3;
      low_seq = start_col[2:0] + beat;
      low_int = start_col[2:0] ^ beat;
      low = interleave ? low_int : low_seq;
      col = start_col;
      col[2:0] = (start_col[2:0] & ~wrap_mask) | (low & wrap_mask);
   end
endmodule

// >>> verification/ddr2_ctl_model.sv
// Purpose: behavioural memory controller on the far side of the burst interface
// Assumes: free-running 320 ns link clock, write strobe centred in each data beat
// Notes: read beats are collected whenever the strobe changes while the memory drives
`timescale 1ns/1ns
module ddr2_ctl_model (
   input wire logic mclk,
   output logic ck,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic bank_select_bit0,
   output logic bank_select_bit1,
   output logic [13:0] addr,
   output logic [7:0] dq_drv,
   output logic dqs_drv,
   output logic write_byte_mask,
   input wire logic [7:0] dq_bus,
   input wire logic dqs_bus,
   input wire logic dq_oe,
   input wire logic ro_oe,
   input wire logic dqsn_oe
);
   logic [7:0] rd_q[$];
   logic saw_ro, saw_dqsn, oe_l, dqs_l;

   // idle levels; the link clock runs free with a phase unrelated to mclk
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      {bank_select_bit1, bank_select_bit0, addr} = 16'h0000;
      dq_drv = 8'h00;
      dqs_drv = 1'b0;
      write_byte_mask = 1'b0;
      {saw_ro, saw_dqsn, oe_l, dqs_l} = 4'h0;
      ck = 1'b0;
      #13;
      forever #160 ck = ~ck;
   end

   // command held one whole link period around the sampling rise
   task automatic cmd(input logic [2:0] c, input logic [1:0] ba, input logic [13:0] a, input logic sel_n);
      @(negedge ck);
      cs_n = sel_n;
      {ras_n, cas_n, we_n} = c;
      {bank_select_bit1, bank_select_bit0} = ba;
      addr = a;
      @(negedge ck);
      cs_n = 1'b1;
      {ras_n, cas_n, we_n} = 3'h7;
      addr = ~a; // stale address must not look valid
   endtask

   // data first, strobe edge half a beat later, both edges used
   task automatic wr_data(input int bl, input logic [63:0] d, input logic [7:0] m);
      for (int k = 0; k < bl; k++) begin
         dq_drv = d[8*k +: 8];
         write_byte_mask = m[k];
         #80;
         dqs_drv = ~dqs_drv;
         #80;
      end
      dq_drv = ~dq_drv; // released bus never repeats the last beat
      write_byte_mask = 1'b0;
   endtask

   // one beat per strobe change while the memory owns the bus
   always @(negedge mclk) begin
      if (dq_oe === 1'b1 && (oe_l !== 1'b1 || dqs_bus !== dqs_l)) begin
         rd_q.push_back(dq_bus);
         saw_ro = saw_ro | ro_oe;
         saw_dqsn = saw_dqsn | dqsn_oe;
      end
      oe_l = dq_oe;
      dqs_l = dqs_bus;
   end
endmodule

// >>> verification/tb_top.sv
// Purpose: self-checking bench for the ddr2 burst interface memory side
// Assumes: apb register access, controller model on the link side
// Notes: one bank is used; a shadow array predicts every read beat
`timescale 1ns/1ns
module tb_top;
   logic mclk, nrst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, dq_out, dq_drv, dq_w;
   logic [31:0] pwdata, prdata, rv;
   logic ck, cs_n, ras_n, cas_n, we_n, bank_select_bit0, bank_select_bit1, er;
   logic [13:0] addr;
   logic dq_oe, dqs_out, dqs_oe, dqs_n_out, dqs_n_oe, dqs_drv, dqs_w, write_byte_mask;
   logic ro_out, ro_oe, ron_out, ron_oe, termination_enable, termination_on;
   logic [7:0] mdl[16];
   int fail_count, checked;

   // the wire takes whichever side has its driver enabled
   assign dq_w = dq_oe ? dq_out : dq_drv;
   assign dqs_w = dqs_oe ? dqs_out : dqs_drv;

   ddr2_burst_if dut_u (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ck(ck),
      .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select_bit0(bank_select_bit0),
      .bank_select_bit1(bank_select_bit1), .addr(addr), .dq_in(dq_w), .dq_out(dq_out), .dq_oe(dq_oe),
      .dqs_in(dqs_w), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .dqs_n_out(dqs_n_out), .dqs_n_oe(dqs_n_oe),
      .write_byte_mask(write_byte_mask), .read_only_strobe_out(ro_out), .read_only_strobe_oe(ro_oe),
      .read_only_strobe_n_out(ron_out), .read_only_strobe_n_oe(ron_oe),
      .termination_enable(termination_enable), .termination_on(termination_on));

   ddr2_ctl_model ctl_u (.mclk(mclk), .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .bank_select_bit0(bank_select_bit0), .bank_select_bit1(bank_select_bit1), .addr(addr),
      .dq_drv(dq_drv), .dqs_drv(dqs_drv), .write_byte_mask(write_byte_mask), .dq_bus(dq_w),
      .dqs_bus(dqs_w), .dq_oe(dq_oe), .ro_oe(ro_oe), .dqsn_oe(dqs_n_oe));

   // core clock
   always #20 mclk = ~mclk;

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // complements and the read strobe pin must mirror the strobe while the memory drives
   always @(negedge mclk) begin
      if (dq_oe === 1'b1) begin
         chk("complement strobe", {31'h0, ~dqs_out}, {31'h0, dqs_n_out});
         chk("read strobe level", {31'h0, dqs_out}, {31'h0, ro_out});
         chk("read strobe complement", {31'h0, ~dqs_out}, {31'h0, ron_out});
         chk("read strobe complement enable", {31'h0, ro_oe & dqs_n_oe}, {31'h0, ron_oe});
      end
   end

   // one apb transfer, held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // column of beat k, wrapped inside the burst block
   function automatic logic [3:0] colf(input logic [3:0] s, input int k, input int bl, input logic il);
      logic [3:0] msk;
      msk = 4'(bl - 1);
      return (s & ~msk) | ((il ? (s ^ 4'(k)) : (s + 4'(k))) & msk);
   endfunction

   task automatic burst_wr(input logic [3:0] s, input int bl, input logic il, input logic [63:0] d,
      input logic [7:0] m);
      ctl_u.cmd(ddr2_burst_pkg::CMD_WR, 2'h1, {10'h000, s}, 1'b0);
      ctl_u.wr_data(bl, d, m);
      for (int k = 0; k < bl; k++) if (!m[k]) mdl[colf(s, k, bl, il)] = d[8*k +: 8];
   endtask

   task automatic burst_rd(input logic [3:0] s, input int bl, input logic il, input logic auto, input logic live);
      int n;
      ctl_u.rd_q.delete();
      ctl_u.saw_ro = 1'b0;
      ctl_u.saw_dqsn = 1'b0;
      ctl_u.cmd(ddr2_burst_pkg::CMD_RD, 2'h1, {3'h0, auto, 6'h00, s}, 1'b0);
      repeat (bl / 2 + 3) @(negedge ck);
      n = ctl_u.rd_q.size();
      chk("read beat count", live ? bl : 0, n);
      for (int k = 0; k < n && k < bl; k++) chk("read beat", mdl[colf(s, k, bl, il)], ctl_u.rd_q[k]);
   endtask

   task give_verdict;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // hang guard, far beyond the few tens of microseconds the tests need
   initial begin
      #400000;
      fail_count++;
      give_verdict;
   end

   initial begin
      {mclk, nrst, psel, penable, pwrite, termination_enable} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      fail_count = 0;
      checked = 0;
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      repeat (4) @(posedge mclk); // controller initialisation taken as done
      apb(1'b0, ddr2_burst_pkg::OFF_CFG, 32'h0);
      chk("cfg reset", {27'h0, ddr2_burst_pkg::CFG_RESET}, rv);
      apb(1'b0, 8'h0c, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, er});
      chk("unmapped data", 32'h0, rv);
      apb(1'b1, ddr2_burst_pkg::OFF_STAT, 32'hffffffff);
      apb(1'b0, ddr2_burst_pkg::OFF_STAT, 32'h0);
      chk("status read only", 32'h0, rv);
      $display("test registers done");
      termination_enable <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("termination disabled", 32'h0, {31'h0, termination_on});
      apb(1'b1, ddr2_burst_pkg::OFF_CFG, 32'h10);
      repeat (4) @(posedge mclk);
      chk("termination applied", 32'h1, {31'h0, termination_on});
      $display("test termination done");
      ctl_u.cmd(ddr2_burst_pkg::CMD_ACT, 2'h2, 14'h0123, 1'b1);
      apb(1'b0, ddr2_burst_pkg::OFF_STAT, 32'h0);
      chk("deselected activate", 32'h0, rv & 32'h3f);
      ctl_u.cmd(ddr2_burst_pkg::CMD_ACT, 2'h1, 14'h1abc, 1'b0);
      apb(1'b0, ddr2_burst_pkg::OFF_ROW, 32'h0);
      chk("row", 32'h1abc, rv);
      apb(1'b0, ddr2_burst_pkg::OFF_STAT, 32'h0);
      chk("open bank", 32'h2, rv & 32'h3f);
      $display("test activate done");
      // fill the block first so masked beats compare against known data
      apb(1'b1, ddr2_burst_pkg::OFF_CFG, 32'h1);
      burst_wr(4'h0, 8, 1'b0, 64'h8877665544332211, 8'h00);
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, ddr2_burst_pkg::OFF_CFG, 32'(m));
         burst_wr(4'(3 + m), m[0] ? 8 : 4, m[1], 64'hf0e1d2c3b4a59687 ^ {8{8'(m << 4)}}, 8'h02);
         burst_rd(4'(6 - m), m[0] ? 8 : 4, m[1], 1'b0, 1'b1);
      end
      chk("strobe pin kept as mask", 32'h0, {31'h0, ctl_u.saw_ro});
      chk("complement strobe on", 32'h1, {31'h0, ctl_u.saw_dqsn});
      $display("test bursts done");
      apb(1'b1, ddr2_burst_pkg::OFF_CFG, 32'h0c);
      // mask pin serves as read strobe now, so a high mask must not drop beats
      ctl_u.cmd(ddr2_burst_pkg::CMD_WR, 2'h1, 14'h0001, 1'b0);
      ctl_u.wr_data(4, 64'h00000000a1b2c3d4, 8'h0f);
      for (int k = 0; k < 4; k++) mdl[colf(4'h1, k, 4, 1'b0)] = 8'(64'ha1b2c3d4 >> (8 * k));
      burst_rd(4'h1, 4, 1'b0, 1'b0, 1'b1);
      chk("read strobe pin", 32'h1, {31'h0, ctl_u.saw_ro});
      chk("complement strobe off", 32'h0, {31'h0, ctl_u.saw_dqsn});
      $display("test strobe options done");
      apb(1'b1, ddr2_burst_pkg::OFF_CFG, 32'h0);
      burst_rd(4'h2, 4, 1'b0, 1'b1, 1'b1);
      apb(1'b0, ddr2_burst_pkg::OFF_STAT, 32'h0);
      chk("bank closed", 32'h0, rv & 32'h3f);
      burst_rd(4'h2, 4, 1'b0, 1'b0, 1'b0);
      $display("test auto close done");
      give_verdict;
   end
endmodule
